/* src/ipr_chan_route.v */
// per-channel enable and switch decode with registered outputs
`timescale 1ns/1ps
`include "ipr_defs.vh"

module ipr_chan_route
(
    // clock and reset
    input  wire       i_clk,
    input  wire       i_rst_n,
    // register fields of this channel
    input  wire       i_in_boost_en,
    input  wire       i_amp_en,
    input  wire [8:0] i_path,
    // analogue controls
    output reg        o_boost_en,
    output reg        o_amp_en,
    output reg        o_amp_to_boost,
    output reg        o_second_pin_to_noninv,
    output reg        o_third_pin_to_noninv,
    output reg        o_first_pin_to_inv,
    output reg        o_noninv_to_mid
);

    // =================================================================
    // decode
    // =================================================================
    always @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_boost_en             <= 1'b0;
            o_amp_en               <= 1'b0;
            o_amp_to_boost         <= 1'b0;
            o_second_pin_to_noninv <= 1'b0;
            o_third_pin_to_noninv  <= 1'b0;
            o_first_pin_to_inv     <= 1'b1;
            o_noninv_to_mid        <= 1'b1;
        end
        else
        begin
            o_boost_en             <= i_in_boost_en;                       // RULE1 RULE2
            // amp needs both enables; boost keeps running without it
            o_amp_en               <= i_in_boost_en & i_amp_en;            // RULE3 RULE4
            o_amp_to_boost         <= i_path[`IPR_BIT_AMP_TO_BOOST];       // RULE5 RULE6
            o_second_pin_to_noninv <= i_path[`IPR_BIT_SECOND_PIN_NONINV];  // RULE7 RULE10
            o_third_pin_to_noninv  <= i_path[`IPR_BIT_THIRD_PIN_NONINV];   // RULE8 RULE11
            o_first_pin_to_inv     <= i_path[`IPR_BIT_FIRST_PIN_INV];      // RULE9 RULE16
            o_noninv_to_mid        <= ~(i_path[`IPR_BIT_SECOND_PIN_NONINV]
                                      | i_path[`IPR_BIT_THIRD_PIN_NONINV]); // RULE12
        end
    end

endmodule // ipr_chan_route

/* src/ipr_defs.vh */
// constants for the input path routing control registers
`ifndef IPR_DEFS_VH
`define IPR_DEFS_VH

// =====================================================================
// register offsets (7-bit register address of the control port)
// =====================================================================
`define IPR_OFS_POWER_CONTROL_ONE   7'h19
`define IPR_OFS_LEFT_INPUT_PATH     7'h20
`define IPR_OFS_RIGHT_INPUT_PATH    7'h21
`define IPR_OFS_POWER_CONTROL_THREE 7'h2f

// =====================================================================
// reset values
// =====================================================================
`define IPR_RST_POWER_CONTROL_ONE   9'h000
`define IPR_RST_LEFT_INPUT_PATH     9'h100
`define IPR_RST_RIGHT_INPUT_PATH    9'h100
`define IPR_RST_POWER_CONTROL_THREE 9'h000

// =====================================================================
// field positions
// =====================================================================
`define IPR_BIT_LEFT_IN_BOOST_EN    5
`define IPR_BIT_RIGHT_IN_BOOST_EN   4
`define IPR_BIT_LEFT_AMP_EN         5
`define IPR_BIT_RIGHT_AMP_EN        4
`define IPR_BIT_AMP_TO_BOOST        3
`define IPR_BIT_SECOND_PIN_NONINV   6
`define IPR_BIT_THIRD_PIN_NONINV    7
`define IPR_BIT_FIRST_PIN_INV       8

// =====================================================================
// control port framing
// =====================================================================
`define IPR_DEV_ADDR_RST            7'h10
`define IPR_BITS_PER_BYTE           4'h8
`define IPR_LAST_BYTE_IDX           2'h2

`endif

/* src/ipr_input_path_ctrl.v */
// input path routing control: two-wire write port and register bank
// What this block does
// RULE1: bit5 power one enables left amp, boost
// RULE2: bit4 power one enables right amp, boost
// RULE3: left amp needs both enables; boost stays
// RULE4: right amp needs both enables, resets 0
// RULE5: left path bit3 joins amp to boost
// RULE6: right path bit3 joins amp to boost
// RULE7: left bit6 puts second pin on noninverting
// RULE8: left bit7 puts third pin on noninverting
// RULE9: left bit8 first pin inverting, resets 1
// RULE10: right bit6 puts second pin on noninverting
// RULE11: right bit7 puts third pin on noninverting
// RULE12: no pin on noninverting means mid reference
// RULE13: software avoids differential pins into boost mixer
// RULE14: brown-out keeps registers; only reset clears
// RULE15: writes ignored in reset; defaults afterwards
// RULE16: right bit8 first pin inverting, resets 1
// RULE17: all nine bits stored; effect after write
`timescale 1ns/1ps
`include "ipr_defs.vh"

module ipr_input_path_ctrl
#(
    parameter [6:0] DEV_ADDR = `IPR_DEV_ADDR_RST
)
(
    // clock and power-on reset
    input  wire I_CLK_SYS,
    input  wire I_RESETN,
    // two-wire control port
    input  wire I_SCLK,
    input  wire I_SDIN,
    output reg  O_SDIN,
    output reg  O_SDIN_OE_N,
    // left channel controls
    output wire O_LEFT_BOOST_EN,
    output wire O_LEFT_AMP_EN,
    output wire O_LEFT_AMP_TO_BOOST,
    output wire O_LEFT_SECOND_PIN_TO_NONINV,
    output wire O_LEFT_THIRD_PIN_TO_NONINV,
    output wire O_LEFT_FIRST_PIN_TO_INV,
    output wire O_LEFT_NONINV_TO_MID,
    // right channel controls
    output wire O_RIGHT_BOOST_EN,
    output wire O_RIGHT_AMP_EN,
    output wire O_RIGHT_AMP_TO_BOOST,
    output wire O_RIGHT_SECOND_PIN_TO_NONINV,
    output wire O_RIGHT_THIRD_PIN_TO_NONINV,
    output wire O_RIGHT_FIRST_PIN_TO_INV,
    output wire O_RIGHT_NONINV_TO_MID
);

    // =================================================================
    // states of the serial receiver
    // =================================================================
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_RECV = 2'h1;
    localparam [1:0] ST_ACK  = 2'h2;
    localparam [1:0] ST_SKIP = 2'h3;

    // =================================================================
    // declarations
    // =================================================================
    reg        scl_s1_q;
    reg        scl_s2_q;
    reg        scl_s3_q;
    reg        sda_s1_q;
    reg        sda_s2_q;
    reg        sda_s3_q;
    reg  [1:0] state_q;
    reg  [1:0] state_d;
    reg  [3:0] bit_cnt_q;
    reg  [3:0] bit_cnt_d;
    reg  [1:0] byte_idx_q;
    reg  [1:0] byte_idx_d;
    reg  [7:0] shift_q;
    reg  [7:0] shift_d;
    reg  [6:0] reg_addr_q;
    reg  [6:0] reg_addr_d;
    reg        data_msb_q;
    reg        data_msb_d;
    reg        wr_q;
    reg        wr_d;
    reg        ack_drive_d;
    reg  [8:0] power_control_one_q;
    reg  [8:0] left_input_path_q;
    reg  [8:0] right_input_path_q;
    reg  [8:0] power_control_three_q;
    wire       scl_rise;
    wire       scl_fall;
    wire       start_seen;
    wire       stop_seen;
    wire [8:0] wr_data;
    wire [1:0] in_boost_en;
    wire [1:0] amp_en;
    wire [8:0] path_sel [0:1];
    wire [1:0] q_boost_en;
    wire [1:0] q_amp_en;
    wire [1:0] q_amp_to_boost;
    wire [1:0] q_second_pin;
    wire [1:0] q_third_pin;
    wire [1:0] q_first_pin;
    wire [1:0] q_noninv_mid;

    // =================================================================
    // pin synchronisers
    // =================================================================
    // third stage only feeds edge detection, never the first stage
    always @(posedge I_CLK_SYS or negedge I_RESETN)
    begin
        if (!I_RESETN)
        begin
            scl_s1_q <= 1'b1;
            scl_s2_q <= 1'b1;
            scl_s3_q <= 1'b1;
            sda_s1_q <= 1'b1;
            sda_s2_q <= 1'b1;
            sda_s3_q <= 1'b1;
        end
        else
        begin
            scl_s1_q <= I_SCLK;
            scl_s2_q <= scl_s1_q;
            scl_s3_q <= scl_s2_q;
            sda_s1_q <= I_SDIN;
            sda_s2_q <= sda_s1_q;
            sda_s3_q <= sda_s2_q;
        end
    end

    assign scl_rise   = scl_s2_q & ~scl_s3_q;
    assign scl_fall   = ~scl_s2_q & scl_s3_q;
    assign start_seen = scl_s2_q & scl_s3_q & ~sda_s2_q & sda_s3_q;
    assign stop_seen  = scl_s2_q & scl_s3_q & sda_s2_q & ~sda_s3_q;

    // =================================================================
    // serial receiver: device address, then address+msb, then lsbs
    // =================================================================
    always @*
    begin
        state_d     = state_q;
        bit_cnt_d   = bit_cnt_q;
        byte_idx_d  = byte_idx_q;
        shift_d     = shift_q;
        reg_addr_d  = reg_addr_q;
        data_msb_d  = data_msb_q;
        wr_d        = 1'b0;
        ack_drive_d = 1'b0;
        if (start_seen)
        begin
            state_d    = ST_RECV;
            bit_cnt_d  = 4'h0;
            byte_idx_d = 2'h0;
        end
        else if (stop_seen)
        begin
            state_d = ST_IDLE;
        end
        else
        begin
            case (state_q)
                ST_RECV:
                begin
                    if (scl_rise && bit_cnt_q != `IPR_BITS_PER_BYTE)
                    begin
                        shift_d   = {shift_q[6:0], sda_s2_q};
                        bit_cnt_d = bit_cnt_q + 4'h1;
                    end
                    else if (scl_fall && bit_cnt_q == `IPR_BITS_PER_BYTE)
                    begin
                        state_d     = ST_ACK;
                        ack_drive_d = 1'b1;
                        if (byte_idx_q == 2'h0)
                        begin
                            // other devices or reads: stay off the line
                            if (shift_q[7:1] != DEV_ADDR || shift_q[0])
                            begin
                                state_d     = ST_SKIP;
                                ack_drive_d = 1'b0;
                            end
                        end
                        else if (byte_idx_q == 2'h1)
                        begin
                            reg_addr_d = shift_q[7:1];
                            data_msb_d = shift_q[0];
                        end
                        else
                        begin
                            wr_d = 1'b1; // RULE17
                        end
                    end
                end
                ST_ACK:
                begin
                    ack_drive_d = 1'b1;
                    if (scl_fall)
                    begin
                        ack_drive_d = 1'b0;
                        bit_cnt_d   = 4'h0;
                        byte_idx_d  = byte_idx_q + 2'h1;
                        if (byte_idx_q == `IPR_LAST_BYTE_IDX)
                        begin
                            state_d = ST_SKIP;
                        end
                        else
                        begin
                            state_d = ST_RECV;
                        end
                    end
                end
                default:
                begin
                    state_d = state_q;
                end
            endcase
        end
    end

    always @(posedge I_CLK_SYS or negedge I_RESETN)
    begin
        if (!I_RESETN)
        begin
            state_q     <= ST_IDLE;
            bit_cnt_q   <= 4'h0;
            byte_idx_q  <= 2'h0;
            shift_q     <= 8'h00;
            reg_addr_q  <= 7'h00;
            data_msb_q  <= 1'b0;
            wr_q        <= 1'b0;
            O_SDIN      <= 1'b0;
            O_SDIN_OE_N <= 1'b1;
        end
        else
        begin
            state_q     <= state_d;
            bit_cnt_q   <= bit_cnt_d;
            byte_idx_q  <= byte_idx_d;
            shift_q     <= shift_d;
            reg_addr_q  <= reg_addr_d;
            data_msb_q  <= data_msb_d;
            wr_q        <= wr_d;
            O_SDIN      <= 1'b0;
            O_SDIN_OE_N <= ~ack_drive_d;
        end
    end

    assign wr_data = {data_msb_q, shift_q};

    // =================================================================
    // register bank
    // =================================================================
    // only the power-on reset clears these; supply dips do nothing
    always @(posedge I_CLK_SYS or negedge I_RESETN)
    begin
        if (!I_RESETN)
        begin
            power_control_one_q   <= `IPR_RST_POWER_CONTROL_ONE;   // RULE15 RULE14
            left_input_path_q     <= `IPR_RST_LEFT_INPUT_PATH;     // RULE9
            right_input_path_q    <= `IPR_RST_RIGHT_INPUT_PATH;    // RULE16
            power_control_three_q <= `IPR_RST_POWER_CONTROL_THREE; // RULE4
        end
        else if (wr_q)
        begin
            // unmapped register addresses are dropped silently
            if (reg_addr_q == `IPR_OFS_POWER_CONTROL_ONE)
            begin
                power_control_one_q <= wr_data; // RULE17
            end
            else if (reg_addr_q == `IPR_OFS_LEFT_INPUT_PATH)
            begin
                left_input_path_q <= wr_data;
            end
            else if (reg_addr_q == `IPR_OFS_RIGHT_INPUT_PATH)
            begin
                right_input_path_q <= wr_data;
            end
            else if (reg_addr_q == `IPR_OFS_POWER_CONTROL_THREE)
            begin
                power_control_three_q <= wr_data;
            end
        end
    end

    // =================================================================
    // channel decode, index 0 left, 1 right
    // =================================================================
    assign in_boost_en = {power_control_one_q[`IPR_BIT_RIGHT_IN_BOOST_EN],
                          power_control_one_q[`IPR_BIT_LEFT_IN_BOOST_EN]};
    assign amp_en      = {power_control_three_q[`IPR_BIT_RIGHT_AMP_EN],
                          power_control_three_q[`IPR_BIT_LEFT_AMP_EN]};
    assign path_sel[0] = left_input_path_q;
    assign path_sel[1] = right_input_path_q;

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1)
        begin : g_chan
            ipr_chan_route u_route
            (
                .i_clk                  (I_CLK_SYS),
                .i_rst_n                (I_RESETN),
                .i_in_boost_en          (in_boost_en[ch]),
                .i_amp_en               (amp_en[ch]),
                .i_path                 (path_sel[ch]),
                .o_boost_en             (q_boost_en[ch]),
                .o_amp_en               (q_amp_en[ch]),
                .o_amp_to_boost         (q_amp_to_boost[ch]),
                .o_second_pin_to_noninv (q_second_pin[ch]),
                .o_third_pin_to_noninv  (q_third_pin[ch]),
                .o_first_pin_to_inv     (q_first_pin[ch]),
                .o_noninv_to_mid        (q_noninv_mid[ch])
            );
        end
    endgenerate

    assign O_LEFT_BOOST_EN              = q_boost_en[0];
    assign O_LEFT_AMP_EN                = q_amp_en[0];
    assign O_LEFT_AMP_TO_BOOST          = q_amp_to_boost[0];
    assign O_LEFT_SECOND_PIN_TO_NONINV  = q_second_pin[0];
    assign O_LEFT_THIRD_PIN_TO_NONINV   = q_third_pin[0];
    assign O_LEFT_FIRST_PIN_TO_INV      = q_first_pin[0];
    assign O_LEFT_NONINV_TO_MID         = q_noninv_mid[0];
    assign O_RIGHT_BOOST_EN             = q_boost_en[1];
    assign O_RIGHT_AMP_EN               = q_amp_en[1];
    assign O_RIGHT_AMP_TO_BOOST         = q_amp_to_boost[1];
    assign O_RIGHT_SECOND_PIN_TO_NONINV = q_second_pin[1];
    assign O_RIGHT_THIRD_PIN_TO_NONINV  = q_third_pin[1];
    assign O_RIGHT_FIRST_PIN_TO_INV     = q_first_pin[1];
    assign O_RIGHT_NONINV_TO_MID        = q_noninv_mid[1];

endmodule // ipr_input_path_ctrl

/* testbench/ipr_ctrl_monitor.sv */
// port assertions for the input path routing control block
`timescale 1ns/1ps
module ipr_ctrl_monitor
(
    // clock, reset and control port
    input logic I_CLK_SYS,
    input logic I_RESETN,
    input logic I_SCLK,
    input logic O_SDIN_OE_N,
    // left channel controls
    input logic O_LEFT_BOOST_EN,
    input logic O_LEFT_AMP_EN,
    input logic O_LEFT_AMP_TO_BOOST,
    input logic O_LEFT_SECOND_PIN_TO_NONINV,
    input logic O_LEFT_THIRD_PIN_TO_NONINV,
    input logic O_LEFT_FIRST_PIN_TO_INV,
    input logic O_LEFT_NONINV_TO_MID,
    // right channel controls
    input logic O_RIGHT_BOOST_EN,
    input logic O_RIGHT_AMP_EN,
    input logic O_RIGHT_AMP_TO_BOOST,
    input logic O_RIGHT_SECOND_PIN_TO_NONINV,
    input logic O_RIGHT_THIRD_PIN_TO_NONINV,
    input logic O_RIGHT_FIRST_PIN_TO_INV,
    input logic O_RIGHT_NONINV_TO_MID
);
    // =========================================================
    // checks
    logic [13:0] outs;
    assign outs = {O_LEFT_BOOST_EN, O_LEFT_AMP_EN, O_LEFT_AMP_TO_BOOST,
        O_LEFT_SECOND_PIN_TO_NONINV, O_LEFT_THIRD_PIN_TO_NONINV,
        O_LEFT_FIRST_PIN_TO_INV, O_LEFT_NONINV_TO_MID, O_RIGHT_BOOST_EN,
        O_RIGHT_AMP_EN, O_RIGHT_AMP_TO_BOOST, O_RIGHT_SECOND_PIN_TO_NONINV,
        O_RIGHT_THIRD_PIN_TO_NONINV, O_RIGHT_FIRST_PIN_TO_INV, O_RIGHT_NONINV_TO_MID};
    // reset also held at the last edge; the first edge has no history yet
    logic rst_held_q;
    always @(posedge I_CLK_SYS)
        rst_held_q <= !I_RESETN;
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_RESETN);
    chk_left_amp_gate:
        assert property (O_LEFT_AMP_EN |-> O_LEFT_BOOST_EN) else $error("left amp alone");
    chk_right_amp_gate:
        assert property (O_RIGHT_AMP_EN |-> O_RIGHT_BOOST_EN) else $error("right amp alone");
    chk_left_mid_ref:
        assert property (O_LEFT_NONINV_TO_MID == !(O_LEFT_SECOND_PIN_TO_NONINV
            || O_LEFT_THIRD_PIN_TO_NONINV)) else $error("left mid reference wrong");
    chk_right_mid_ref:
        assert property (O_RIGHT_NONINV_TO_MID == !(O_RIGHT_SECOND_PIN_TO_NONINV
            || O_RIGHT_THIRD_PIN_TO_NONINV)) else $error("right mid reference wrong");
    // a change may only land while the data byte is acknowledged
    chk_change_in_ack:
        assert property (!$stable(outs) |-> !O_SDIN_OE_N) else $error("change outside ack");
    chk_change_sclk_low:
        assert property (!$stable(outs) |-> !I_SCLK) else $error("change with clock high");
    chk_rst_first_pin:
        assert property (disable iff (1'b0) !I_RESETN && rst_held_q |-> O_LEFT_FIRST_PIN_TO_INV
            && O_RIGHT_FIRST_PIN_TO_INV) else $error("first pin not joined in reset");
    chk_rst_enables:
        assert property (disable iff (1'b0) !I_RESETN && rst_held_q |-> !(O_LEFT_BOOST_EN
            || O_RIGHT_BOOST_EN || O_LEFT_AMP_EN || O_RIGHT_AMP_EN))
            else $error("enable on in reset");
endmodule // ipr_ctrl_monitor

bind ipr_input_path_ctrl ipr_ctrl_monitor u_ipr_ctrl_monitor (.*);

/* testbench/ipr_input_path_ctrl_test.sv */
// self-checking bench for the input path routing control block
`timescale 1ns/1ps
module ipr_input_path_ctrl_test;
    // =========================================================
    // design hookup
    localparam logic [6:0] DEV = 7'h10;
    logic I_CLK_SYS, I_RESETN, I_SCLK, I_SDIN, O_SDIN, O_SDIN_OE_N;
    logic O_LEFT_BOOST_EN, O_LEFT_AMP_EN, O_LEFT_AMP_TO_BOOST, O_LEFT_SECOND_PIN_TO_NONINV;
    logic O_LEFT_THIRD_PIN_TO_NONINV, O_LEFT_FIRST_PIN_TO_INV, O_LEFT_NONINV_TO_MID;
    logic O_RIGHT_BOOST_EN, O_RIGHT_AMP_EN, O_RIGHT_AMP_TO_BOOST, O_RIGHT_SECOND_PIN_TO_NONINV;
    logic O_RIGHT_THIRD_PIN_TO_NONINV, O_RIGHT_FIRST_PIN_TO_INV, O_RIGHT_NONINV_TO_MID;
    logic        sda_m;
    logic        rnw;
    logic [8:0]  p1, lp, rp, p3;
    logic [2:0]  acks;
    logic [13:0] obs;
    int          fails, total_checks;
    // the 048 steps on both paths put the second pin on noninverting and join the amp to the boost mixer
    logic [15:0] steps [13] = '{{7'h19, 9'h020}, {7'h2f, 9'h020}, {7'h2f, 9'h000},
        {7'h2f, 9'h1f0}, {7'h19, 9'h010}, {7'h19, 9'h1ff}, {7'h20, 9'h048},
        {7'h20, 9'h080}, {7'h20, 9'h1c0}, {7'h21, 9'h048}, {7'h21, 9'h0b7},
        {7'h21, 9'h000}, {7'h19, 9'h000}};
    // wire is pulled high; either side may only pull it low
    assign I_SDIN = sda_m & (O_SDIN_OE_N | O_SDIN);
    assign obs = {O_LEFT_BOOST_EN, O_LEFT_AMP_EN, O_LEFT_AMP_TO_BOOST,
        O_LEFT_SECOND_PIN_TO_NONINV, O_LEFT_THIRD_PIN_TO_NONINV,
        O_LEFT_FIRST_PIN_TO_INV, O_LEFT_NONINV_TO_MID, O_RIGHT_BOOST_EN,
        O_RIGHT_AMP_EN, O_RIGHT_AMP_TO_BOOST, O_RIGHT_SECOND_PIN_TO_NONINV,
        O_RIGHT_THIRD_PIN_TO_NONINV, O_RIGHT_FIRST_PIN_TO_INV, O_RIGHT_NONINV_TO_MID};
    ipr_input_path_ctrl #(.DEV_ADDR(DEV)) u_ipr_input_path_ctrl (.*);
    initial
    begin
        I_CLK_SYS = 1'b0;
        forever #12.5 I_CLK_SYS = ~I_CLK_SYS;
    end
    // =========================================================
    // expectations
    function automatic logic [13:0] expv();
        return {p1[5], p1[5] & p3[5], lp[3], lp[6], lp[7], lp[8], ~(lp[6] | lp[7]),
                p1[4], p1[4] & p3[4], rp[3], rp[6], rp[7], rp[8], ~(rp[6] | rp[7])};
    endfunction
    task automatic mreset();
        p1 = 9'h000;
        lp = 9'h100;
        rp = 9'h100;
        p3 = 9'h000;
    endtask
    task automatic cmp_out(input string what);
        total_checks++;
        if (obs !== expv())
        begin
            fails++;
            $display("FAIL %s expected %h seen %h", what, expv(), obs);
        end
    endtask
    task automatic cmp_ack(input string what, input logic [2:0] exp);
        total_checks++;
        if (acks !== exp)
        begin
            fails++;
            $display("FAIL %s expected %b seen %b", what, exp, acks);
        end
    endtask
    // =========================================================
    // two-wire port, 8 clocks a phase to clear the synchroniser
    task automatic tick(input int n);
        repeat (n) @(negedge I_CLK_SYS);
    endtask
    task automatic sbit(input logic b, output logic ack);
        sda_m = b;
        tick(8);
        I_SCLK = 1'b1;
        tick(8);
        ack = (I_SDIN === 1'b0);
        I_SCLK = 1'b0;
    endtask
    task automatic sbyte(input logic [7:0] v, output logic ack);
        for (int i = 7; i >= 0; i--)
            sbit(v[i], ack);
        sbit(1'b1, ack);
    endtask
    task automatic wr(input logic [6:0] dev, input logic [6:0] ra, input logic [8:0] d);
        sda_m = 1'b1;
        I_SCLK = 1'b1;
        tick(8);
        sda_m = 1'b0;
        tick(8);
        I_SCLK = 1'b0;
        sbyte({dev, rnw}, acks[2]);
        sbyte({ra, d[8]}, acks[1]);
        sbyte(d[7:0], acks[0]);
        sda_m = 1'b0;
        tick(8);
        I_SCLK = 1'b1;
        tick(8);
        sda_m = 1'b1;
        tick(8);
        if (dev == DEV && !rnw && I_RESETN === 1'b1)
            case (ra)
                7'h19: p1 = d;
                7'h20: lp = d;
                7'h21: rp = d;
                7'h2f: p3 = d;
                default: ;
            endcase
    endtask
    task automatic close_out();
        $display("checks %0d failures %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // =========================================================
    // tests
    initial
    begin
        I_RESETN = 1'b0;
        I_SCLK = 1'b1;
        sda_m = 1'b1;
        rnw = 1'b0;
        fails = 0;
        total_checks = 0;
        mreset();
        tick(5);
        cmp_out("reset values");
        I_RESETN = 1'b1;
        tick(5);
        foreach (steps[i])
        begin
            wr(DEV, steps[i][15:9], steps[i][8:0]);
            cmp_ack("write acks", 3'b111);
            cmp_out("routing");
        end
        wr(DEV, 7'h2f, 9'h030);
        wr(DEV, 7'h20, 9'h0c8);
        wr(DEV ^ 7'h01, 7'h20, 9'h000);
        cmp_ack("foreign device", 3'b000);
        cmp_out("foreign device");
        // read frames are refused: this port only takes writes
        rnw = 1'b1;
        wr(DEV, 7'h20, 9'h000);
        rnw = 1'b0;
        cmp_ack("read bit refused", 3'b000);
        cmp_out("read bit refused");
        wr(DEV, 7'h22, 9'h000);
        cmp_ack("unmapped acks", 3'b111);
        tick(400);
        cmp_out("idle hold");
        // reset mid-run must bring every default back
        I_RESETN = 1'b0;
        mreset();
        tick(3);
        cmp_out("second reset");
        wr(DEV, 7'h19, 9'h030);
        cmp_ack("write during reset", 3'b000);
        I_RESETN = 1'b1;
        tick(5);
        cmp_out("write during reset");
        wr(DEV, 7'h21, 9'h0c8);
        cmp_ack("after reset", 3'b111);
        cmp_out("after reset");
        close_out();
    end
    // a frame is about 470 clocks; the test runs 20 frames and the limit allows about 42
    initial
    begin
        #500000;
        fails++;
        close_out();
    end
endmodule // ipr_input_path_ctrl_test
